// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top
  import tsf_pkg::*;
;
  // ********
  // signals and design
  // ********
  logic              core_clk;
  logic              rst_n;
  tsf_bus_req_t      req;
  tsf_events_t       ev;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              cnt_reinit;
  logic              update_event;
  logic              counter_enable;
  logic [NCH-1:0]    chan_input_mode;
  logic [DATA_W-1:0] rv;
  int                fail_count;
  int                checked;

  tsf_top dut (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .bus_req         (req),
    .tmr_evt         (ev),
    .rdata           (rdata),
    .irq             (irq),
    .cnt_reinit      (cnt_reinit),
    .update_event    (update_event),
    .counter_enable  (counter_enable),
    .chan_input_mode (chan_input_mode)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ********
  // helpers
  // ********
  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge core_clk);
    req.wr    <= 1'b0;
  endtask

  // read data is taken one step after the edge that registers it
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge core_clk);
    req.rd   <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic st(input logic [DATA_W-1:0] exp);
    rd(OFS_STATUS);
    chk(rv, exp);
  endtask

  // misc bits: trig_edge, trig_reinit, com, ovf, rep_zero, break_act, count_down
  function automatic tsf_events_t evm(input logic [3:0] cp, input logic [3:0] cm,
                                      input logic [3:0] cr, input logic [6:0] misc);
    evm = {cp, cm, cr, misc};
  endfunction

  task automatic pulse(input tsf_events_t m, input int n);
    @(posedge core_clk);
    ev <= tsf_events_t'(ev | m);
    repeat (n) @(posedge core_clk);
    ev <= tsf_events_t'(ev & ~m);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    st(32'h0);
    rd(OFS_EGEN);
    chk(rv, 32'h0);
    rd(8'h3c);
    chk(rv, 32'h0);
    @(posedge core_clk);
    #1 chk(rdata, 32'h0);
    chk(irq, 1'b0);
    chk(counter_enable, 1'b0);
  endtask

  task automatic t_update;
    wr(OFS_CTRL, 32'h0);
    pulse(evm(4'h0, 4'h0, 4'h0, 7'h08), 1);
    #1 chk(update_event, 32'h0);
    st(32'h0);
    @(posedge core_clk);
    ev.rep_zero <= 1'b1;
    pulse(evm(4'h0, 4'h0, 4'h0, 7'h08), 1);
    #1 chk(update_event, 32'h1);
    st(32'h1);
    wr(OFS_STATUS, 32'hffff_feff);
    st(32'h1);
    wr(OFS_STATUS, 32'hffff_fefe);
    st(32'h0);
    wr(OFS_CTRL, 32'h2);
    pulse(evm(4'h0, 4'h0, 4'h0, 7'h08), 1);
    #1 chk(update_event, 32'h0);
    st(32'h0);
  endtask

  // every pairing of update_disable and update_request_source
  task automatic t_reinit;
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CTRL, 32'(i) << UPD_DIS_BIT);
      wr(OFS_EGEN, 32'h1);
      #1 chk(cnt_reinit, 1'b1);
      chk(update_event, (i % 2 == 0) ? 32'h1 : 32'h0);
      st((i == 0) ? 32'h1 : 32'h0);
      wr(OFS_STATUS, 32'h0);
      pulse(evm(4'h0, 4'h0, 4'h0, 7'h20), 1);
      st((i == 0) ? 32'h1 : 32'h0);
      wr(OFS_STATUS, 32'h0);
    end
    wr(OFS_CTRL, 32'h0);
  endtask

  task automatic t_chan;
    wr(OFS_CHMODE, 32'h0);
    pulse(evm(4'hf, 4'h0, 4'h0, 7'h0), 2);
    st(32'h0);
    wr(OFS_CTRL, 32'h20);
    pulse(evm(4'h0, 4'h1, 4'h0, 7'h0), 1);
    st(32'h0);
    @(posedge core_clk);
    ev.count_down <= 1'b1;
    pulse(evm(4'h0, 4'h1, 4'h0, 7'h0), 1);
    st(32'h2);
    wr(OFS_CTRL, 32'h0);
    pulse(evm(4'h0, 4'h2, 4'h0, 7'h0), 1);
    st(32'h6);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_CHMODE, 32'h9);
    #1 chk(chan_input_mode, 4'h9);
    pulse(evm(4'h0, 4'hf, 4'h0, 7'h0), 1);
    st(32'hc);
    wr(OFS_STATUS, 32'h0);
    pulse(evm(4'h9, 4'h0, 4'h0, 7'h0), 1);
    st(32'h12);
    pulse(evm(4'h9, 4'h0, 4'h0, 7'h0), 1);
    st(32'h1212);
    wr(OFS_STATUS, ~32'h300);
    st(32'h1012);
    pulse(evm(4'h0, 4'h0, 4'h1, 7'h0), 1);
    st(32'h1010);
    pulse(evm(4'h1, 4'h0, 4'h0, 7'h0), 1);
    st(32'h1012);
    wr(OFS_STATUS, ~32'h102);
    st(32'h1010);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_CHMODE, 32'h0);
  endtask

  task automatic t_break;
    @(posedge core_clk);
    ev.break_act <= 1'b1;
    st(32'h80);
    wr(OFS_STATUS, 32'h0);
    st(32'h80);
    @(posedge core_clk);
    ev.break_act <= 1'b0;
    st(32'h80);
    wr(OFS_STATUS, 32'h0);
    st(32'h0);
  endtask

  task automatic t_trig_com;
    for (int m = 0; m < 8; m++)
    begin
      wr(OFS_SLAVE, 32'(m));
      pulse(evm(4'h0, 4'h0, 4'h0, 7'h40), 1);
      st((m != 0 && m != 5) ? 32'h40 : 32'h0);
      wr(OFS_STATUS, 32'h0);
    end
    pulse(evm(4'h0, 4'h0, 4'h0, 7'h10), 1);
    st(32'h20);
    wr(OFS_STATUS, 32'h0);
    st(32'h0);
    // clear and event land on the same edge
    fork
      wr(OFS_STATUS, 32'h0);
      pulse(evm(4'h0, 4'h0, 4'h0, 7'h10), 1);
    join
    st(32'h20);
    wr(OFS_STATUS, 32'h0);
  endtask

  task automatic t_enable;
    wr(OFS_CTRL, 32'h1);
    #1 chk(counter_enable, 1'b1);
    st(32'h1e);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_STATUS, 32'h0);
  endtask

  task automatic t_irq;
    rd(OFS_IRQ_STAT);
    wr(OFS_IRQ_MASK, 32'h20);
    rd(OFS_IRQ_MASK);
    chk(rv, 32'h20);
    pulse(evm(4'h0, 4'h0, 4'h0, 7'h10), 1);
    #1 chk(irq, 1'b1);
    rd(OFS_IRQ_STAT);
    chk(rv, 32'h20);
    chk(irq, 1'b0);
    st(32'h20);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    pulse(evm(4'h0, 4'h0, 4'h0, 7'h10), 1);
    #1 chk(irq, 1'b0);
    rd(OFS_IRQ_STAT);
    chk(rv, 32'h20);
    wr(OFS_STATUS, 32'h0);
  endtask

  // ********
  // sequence and watchdog
  // ********
  initial
  begin
    fail_count = 0;
    checked    = 0;
    rst_n      = 1'b0;
    req        = '0;
    ev         = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_update;
    t_reinit;
    t_chan;
    t_break;
    t_trig_com;
    t_enable;
    t_irq;
    end_sim;
  end

  // the scenarios need well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim;
  end
endmodule

// ===== tsf_chan.sv
`timescale 1ns/10ps
module tsf_chan
  import tsf_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic input_mode,
  input  wire logic cap,
  input  wire logic cmp_hit,
  input  wire logic ccr_rd,
  input  wire logic en_rise,
  input  wire logic sw_clr_evt,
  input  wire logic sw_clr_ovr,
  output logic      evt_set,
  output logic      ovr_set,
  output logic      evt_flag_r,
  output logic      ovr_flag_r
);

  logic evt_clr;

  assign evt_set = (input_mode ? cap : cmp_hit) | en_rise;
  assign evt_clr = sw_clr_evt | (input_mode & ccr_rd);
  assign ovr_set = input_mode & cap & evt_flag_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_flag_r <= 1'b0;
    else
      evt_flag_r <= tsf_sticky(evt_flag_r, evt_set, evt_clr);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ovr_flag_r <= 1'b0;
    else
      ovr_flag_r <= tsf_sticky(ovr_flag_r, ovr_set, sw_clr_ovr);
  end

  a_ovr_input_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ovr_flag_r) |-> $past(input_mode) && $past(cap) && $past(evt_flag_r))
    else $error("overcapture set without a pending capture in input mode");

  a_ovr_clear_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_clr_ovr && !ovr_set ##1 !ovr_set |=> !ovr_flag_r)
    else $error("overcapture flag came back without a new overcapture");

  a_ccr_read_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
    input_mode && ccr_rd && !cap && !en_rise |=> !evt_flag_r)
    else $error("capture register read did not clear the channel flag");

endmodule

// ===== tsf_irq.sv
`timescale 1ns/10ps
module tsf_irq
  import tsf_pkg::*;
#(
  parameter int W = STAT_W
)
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] evt,
  input  wire logic         rd_clr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] mask_wdata,
  output logic      [W-1:0] stat_r,
  output logic      [W-1:0] mask_r,
  output logic              irq_r
);

  logic [W-1:0] stat_nxt;
  logic [W-1:0] mask_nxt;

  // a read clears, but an event in that cycle stays latched
  assign stat_nxt = evt | (stat_r & ~{W{rd_clr}});
  assign mask_nxt = mask_wr ? mask_wdata : mask_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_r <= '0;
    else
      stat_r <= stat_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= '0;
    else
      mask_r <= mask_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(stat_nxt & mask_nxt);
  end

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (irq_r == |(stat_r & mask_r)))
    else $error("interrupt output does not follow masked status");

endmodule

// ===== tsf_pkg.sv
package tsf_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          NCH          = 4;
  localparam int          STAT_W       = 13;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_CHMODE   = 8'h04;
  localparam logic [7:0]  OFS_SLAVE    = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_EGEN     = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h24;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          UPD_BIT      = 0;
  localparam int          CC_LSB       = 1;
  localparam int          COM_BIT      = 5;
  localparam int          TRIG_BIT     = 6;
  localparam int          BRK_BIT      = 7;
  localparam int          RSV_BIT      = 8;
  localparam int          OVR_LSB      = 9;
  localparam int          CNT_EN_BIT   = 0;
  localparam int          UPD_DIS_BIT  = 1;
  localparam int          UPD_SRC_BIT  = 2;
  localparam int          ALIGN_LSB    = 5;
  localparam int          UPD_GEN_BIT  = 0;
  localparam int          SLV_W        = 3;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [2:0]  SLV_DISABLED = 3'h0;
  localparam logic [2:0]  SLV_GATED    = 3'h5;

  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'b00,
    ALIGN_DOWN = 2'b01,
    ALIGN_UP   = 2'b10,
    ALIGN_BOTH = 2'b11
  } tsf_align_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tsf_bus_req_t;

  typedef struct packed {
    logic [NCH-1:0] cap;
    logic [NCH-1:0] cmp;
    logic [NCH-1:0] ccr_rd;
    logic           trig_edge;
    logic           trig_reinit;
    logic           com;
    logic           ovf;
    logic           rep_zero;
    logic           break_act;
    logic           count_down;
  } tsf_events_t;

  // set beats clear so an event in the clearing cycle survives
  function automatic logic tsf_sticky(input logic q, input logic set, input logic clr);
    tsf_sticky = set | (q & ~clr);
  endfunction

endpackage

// ===== tsf_top.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module tsf_top
  import tsf_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire tsf_bus_req_t bus_req,
  input  wire tsf_events_t  tmr_evt,
  output logic [DATA_W-1:0] rdata,
  output logic              irq,
  output logic              cnt_reinit,
  output logic              update_event,
  output logic              counter_enable,
  output logic [NCH-1:0]    chan_input_mode
);

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic              wr_ctrl;
  logic              wr_chmode;
  logic              wr_slave;
  logic              wr_status;
  logic              wr_egen;
  logic              wr_mask;
  logic              rd_irq_stat;
  logic              upd_gen;
  logic [DATA_W-1:0] ctrl_r;
  logic [NCH-1:0]    chmode_r;
  logic [SLV_W-1:0]  slave_r;
  logic              cnt_en_prev_r;
  logic              cnt_en_rise;
  logic              upd_dis;
  logic              upd_src;
  tsf_align_t        align_sel;

  assign wr_ctrl     = bus_req.wr && (bus_req.addr == OFS_CTRL);
  assign wr_chmode   = bus_req.wr && (bus_req.addr == OFS_CHMODE);
  assign wr_slave    = bus_req.wr && (bus_req.addr == OFS_SLAVE);
  assign wr_status   = bus_req.wr && (bus_req.addr == OFS_STATUS);
  assign wr_egen     = bus_req.wr && (bus_req.addr == OFS_EGEN);
  assign wr_mask     = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);
  assign rd_irq_stat = bus_req.rd && (bus_req.addr == OFS_IRQ_STAT);
  assign upd_gen     = wr_egen && bus_req.wdata[UPD_GEN_BIT];
  assign upd_dis     = ctrl_r[UPD_DIS_BIT];
  assign upd_src     = ctrl_r[UPD_SRC_BIT];
  assign align_sel   = tsf_align_t'(ctrl_r[ALIGN_LSB+1:ALIGN_LSB]);
  assign cnt_en_rise = ctrl_r[CNT_EN_BIT] && !cnt_en_prev_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= bus_req.wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      chmode_r <= '0;
    else if (wr_chmode)
      chmode_r <= bus_req.wdata[NCH-1:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      slave_r <= SLV_DISABLED;
    else if (wr_slave)
      slave_r <= bus_req.wdata[SLV_W-1:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_en_prev_r <= 1'b0;
    else
      cnt_en_prev_r <= ctrl_r[CNT_EN_BIT];
  end

  // ****************************************************************
  // compare qualification
  // ****************************************************************
  function automatic logic cmp_qual(input tsf_align_t sel, input logic down);
    unique case (sel)
      ALIGN_EDGE: cmp_qual = 1'b1;
      ALIGN_DOWN: cmp_qual = down;
      ALIGN_UP:   cmp_qual = ~down;
      ALIGN_BOTH: cmp_qual = 1'b1;
    endcase
  endfunction

  logic cmp_ok;

  assign cmp_ok = cmp_qual(align_sel, tmr_evt.count_down);

  // ****************************************************************
  // channel flags
  // ****************************************************************
  logic [NCH-1:0] evt_set;
  logic [NCH-1:0] ovr_set;
  logic [NCH-1:0] evt_flag;
  logic [NCH-1:0] ovr_flag;

  // zero written clears, a one leaves the flag alone
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      tsf_chan u_chan (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .input_mode (chmode_r[ch]),
        .cap        (tmr_evt.cap[ch]),
        .cmp_hit    (tmr_evt.cmp[ch] && cmp_ok),
        .ccr_rd     (tmr_evt.ccr_rd[ch]),
        .en_rise    (cnt_en_rise),
        .sw_clr_evt (wr_status && !bus_req.wdata[CC_LSB+ch]),
        .sw_clr_ovr (wr_status && !bus_req.wdata[OVR_LSB+ch]),
        .evt_set    (evt_set[ch]),
        .ovr_set    (ovr_set[ch]),
        .evt_flag_r (evt_flag[ch]),
        .ovr_flag_r (ovr_flag[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // break, trigger, commutation and update flags
  // ****************************************************************
  logic brk_r;
  logic trig_r;
  logic com_r;
  logic upd_r;
  logic brk_clr;
  logic trig_set;
  logic upd_set;
  logic upd_evt;
  logic clr_upd;

  assign brk_clr  = wr_status && !bus_req.wdata[BRK_BIT] && !tmr_evt.break_act;
  assign trig_set = tmr_evt.trig_edge && (slave_r != SLV_DISABLED)
                    && (slave_r != SLV_GATED);
  assign upd_set  = (!upd_dis && tmr_evt.ovf && tmr_evt.rep_zero)
                    || (!upd_dis && !upd_src && (upd_gen || tmr_evt.trig_reinit));
  assign upd_evt  = !upd_dis && ((tmr_evt.ovf && tmr_evt.rep_zero) || upd_gen
                    || tmr_evt.trig_reinit);
  assign clr_upd  = wr_status && !bus_req.wdata[UPD_BIT];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      brk_r <= 1'b0;
    else
      brk_r <= tsf_sticky(brk_r, tmr_evt.break_act, brk_clr);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_r <= 1'b0;
    else
      trig_r <= tsf_sticky(trig_r, trig_set, wr_status && !bus_req.wdata[TRIG_BIT]);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      com_r <= 1'b0;
    else
      com_r <= tsf_sticky(com_r, tmr_evt.com, wr_status && !bus_req.wdata[COM_BIT]);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      upd_r <= 1'b0;
    else
      upd_r <= tsf_sticky(upd_r, upd_set, clr_upd);
  end

  // update pulses go out even when the flag is held back by source select
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reinit   <= 1'b0;
      update_event <= 1'b0;
    end
    else
    begin
      cnt_reinit   <= upd_gen;
      update_event <= upd_evt;
    end
  end

  assign counter_enable  = ctrl_r[CNT_EN_BIT];
  assign chan_input_mode = chmode_r;

  // ****************************************************************
  // status assembly, interrupt and read-back
  // ****************************************************************
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] status_set;
  logic [STAT_W-1:0] irq_stat;
  logic [STAT_W-1:0] irq_mask;
  logic [DATA_W-1:0] rdata_nxt;

  assign status     = {ovr_flag, 1'b0, brk_r, trig_r, com_r, evt_flag, upd_r};
  assign status_set = {ovr_set, 1'b0, tmr_evt.break_act && !brk_r, trig_set,
                       tmr_evt.com, evt_set, upd_set};

  tsf_irq #(.W(STAT_W)) u_irq (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .evt        (status_set),
    .rd_clr     (rd_irq_stat),
    .mask_wr    (wr_mask),
    .mask_wdata (bus_req.wdata[STAT_W-1:0]),
    .stat_r     (irq_stat),
    .mask_r     (irq_mask),
    .irq_r      (irq)
  );

  always_comb
  begin
    rdata_nxt = '0;
    unique case (bus_req.addr)
      OFS_CTRL:     rdata_nxt = ctrl_r;
      OFS_CHMODE:   rdata_nxt[NCH-1:0] = chmode_r;
      OFS_SLAVE:    rdata_nxt[SLV_W-1:0] = slave_r;
      OFS_STATUS:   rdata_nxt[STAT_W-1:0] = status;
      OFS_IRQ_STAT: rdata_nxt[STAT_W-1:0] = irq_stat;
      OFS_IRQ_MASK: rdata_nxt[STAT_W-1:0] = irq_mask;
      default:      rdata_nxt = '0;
    endcase
  end

  // unmapped and write-only offsets read zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (bus_req.rd)
      rdata <= rdata_nxt;
    else
      rdata <= '0;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_rsv_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == OFS_STATUS |=> rdata[RSV_BIT] == 1'b0)
    else $error("reserved status bit read as one");

  a_brk_held_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    tmr_evt.break_act |=> brk_r)
    else $error("break flag low while break input active");

  a_trig_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    !trig_r && tmr_evt.trig_edge && slave_r == SLV_GATED |=> !trig_r)
    else $error("trigger flag set in gated slave mode");

  a_com_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    tmr_evt.com |=> com_r)
    else $error("commutation event did not set its flag");

  a_cmp_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    !chmode_r[0] && tmr_evt.cmp[0] && cmp_ok |=> evt_flag[0])
    else $error("compare match did not set channel one flag");

  a_enable_sets_cc: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ctrl_r[CNT_EN_BIT]) |=> evt_flag == {NCH{1'b1}})
    else $error("counter enable did not set channel flags");

  a_upd_ovf: assert property (@(posedge core_clk) disable iff (!rst_n)
    !upd_dis && tmr_evt.ovf && tmr_evt.rep_zero |=> upd_r ##0 update_event)
    else $error("overflow update missing");

  a_upd_src_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !upd_r && (upd_src || upd_dis) && (upd_gen || tmr_evt.trig_reinit)
    && !(tmr_evt.ovf && tmr_evt.rep_zero) |=> !upd_r)
    else $error("update flag set by reinit with source select on");

  a_gen_reinit: assert property (@(posedge core_clk) disable iff (!rst_n)
    upd_gen |=> cnt_reinit ##1 !cnt_reinit || $past(upd_gen))
    else $error("update generate did not give one reinit pulse");

  a_one_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(upd_r) |-> $past(clr_upd) && !$past(upd_set))
    else $error("update flag dropped without a zero write");

endmodule
